// *** design/dbg_status_regs.sv ***
// Purpose: processor-status debug register group with oscillator counters
// Assumes: single-cycle register port, counts driven by on-chip oscillators
// Notes: oscillator counters sit on a non-reset domain of flip-flops
`timescale 1ns/1ps
`default_nettype none
module dbg_status_regs (
    input  wire logic                            core_clk,
    input  wire logic                            rst_n,
    input  wire dbg_status_pkg::reg_req_type     req,
    input  wire logic                            in_debug_mode,
    input  wire dbg_status_pkg::debug_entry_type entry,
    input  wire logic [3:0]                      osc_pulse,
    output logic [31:0]                          rdata,
    output logic                                 rvalid,
    output logic [1:0]                           osc_enable,
    output logic [7:0]                           thread_stop,
    output logic [7:0]                           fetch_thread,
    output logic [4:0]                           fetch_register
);
    dbg_status_pkg::ctrl_state_type state_reg;
    dbg_status_pkg::ctrl_state_type state_next;
    // Power-up value only; system reset leaves the counts alone
    logic [15:0] osc_count_reg [dbg_status_pkg::OSC_COUNT] = '{default: 16'h0000};
    logic [31:0] scratch_reg [dbg_status_pkg::SCRATCH_WORDS];
    logic [3:0]  osc_meta_reg;
    logic [3:0]  osc_sync_reg;
    logic [3:0]  osc_last_reg;
    logic        scratch_hit;
    logic [2:0]  scratch_sel;
    logic [1:0]  lowest_hit;
    logic [31:0] read_word;

    assign scratch_sel = req.idx[2:0];
    assign scratch_hit = (req.idx & dbg_status_pkg::SCRATCH_MASK) == dbg_status_pkg::SCRATCH_IDX;

    // Oscillator edges synchronised; no reset so counts survive system reset
    always_ff @(posedge core_clk) begin
        osc_meta_reg <= osc_pulse;
        osc_sync_reg <= osc_meta_reg;
        osc_last_reg <= osc_sync_reg;
    end

    genvar g;
    generate
        for (g = 0; g < dbg_status_pkg::OSC_COUNT; g++) begin : g_osc
            logic run;
            assign run = (g < 2) ? state_reg.osc_en[dbg_status_pkg::OSC_CORE_BIT]
                                 : state_reg.osc_en[dbg_status_pkg::OSC_PER_BIT];
            always_ff @(posedge core_clk) begin
                if (run && osc_sync_reg[g] && !osc_last_reg[g]) begin
                    osc_count_reg[g] <= osc_count_reg[g] + 16'h0001;
                end
            end
        end
        for (g = 0; g < dbg_status_pkg::SCRATCH_WORDS; g++) begin : g_scr
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    scratch_reg[g] <= 32'h0000_0000;
                end else if (req.wr && in_debug_mode && scratch_hit && scratch_sel == 3'(g)) begin
                    scratch_reg[g] <= req.wdata;
                end
            end
        end
    endgenerate

    always_comb begin
        lowest_hit = 2'h0;
        for (int i = 3; i >= 0; i--) begin
            if (entry.hits[i]) begin
                lowest_hit = 2'(i);
            end
        end
    end

    always_comb begin
        read_word = 32'h0000_0000;
        case (req.idx)
            dbg_status_pkg::OSC_CTRL_IDX:  read_word = {30'h0, state_reg.osc_en};
            dbg_status_pkg::TILE_CELL_IDX: read_word = {16'h0, osc_count_reg[0]};
            dbg_status_pkg::TILE_WIRE_IDX: read_word = {16'h0, osc_count_reg[1]};
            dbg_status_pkg::PER_CELL_IDX:  read_word = {16'h0, osc_count_reg[2]};
            dbg_status_pkg::PER_WIRE_IDX:  read_word = {16'h0, osc_count_reg[3]};
            dbg_status_pkg::RAM_SIZE_IDX:
                read_word = dbg_status_pkg::RAM_SIZE_BYTES & dbg_status_pkg::RAM_SIZE_MASK;
            dbg_status_pkg::STATUS_IDX:    read_word = state_reg.status;
            dbg_status_pkg::PC_IDX:        read_word = state_reg.pc;
            dbg_status_pkg::SP_IDX:        read_word = state_reg.sp;
            dbg_status_pkg::FETCH_THR_IDX: read_word = {24'h0, state_reg.fetch_thr};
            dbg_status_pkg::FETCH_REG_IDX: read_word = {27'h0, state_reg.fetch_reg};
            dbg_status_pkg::CAUSE_IDX:
                read_word = {14'h0, state_reg.source, state_reg.cause_thr, 5'h0, state_reg.cause};
            dbg_status_pkg::TRIG_DATA_IDX: read_word = state_reg.data;
            dbg_status_pkg::STOP_MASK_IDX: read_word = {24'h0, state_reg.stop_mask};
            default: begin
                if (scratch_hit) begin
                    read_word = scratch_reg[scratch_sel];
                end
            end
        endcase
    end

    always_comb begin
        state_next = state_reg;
        state_next.rvalid = req.rd;
        if (req.rd) begin
            state_next.rdata = read_word;
        end
        if (req.wr && req.idx == dbg_status_pkg::OSC_CTRL_IDX) begin
            state_next.osc_en = req.wdata[1:0];
        end
        if (req.wr && in_debug_mode) begin
            case (req.idx)
                dbg_status_pkg::STATUS_IDX:
                    state_next.status = (req.wdata & dbg_status_pkg::STATUS_WMASK)
                                      | (state_reg.status & ~dbg_status_pkg::STATUS_WMASK);
                dbg_status_pkg::PC_IDX:        state_next.pc = req.wdata;
                dbg_status_pkg::SP_IDX:        state_next.sp = req.wdata;
                dbg_status_pkg::FETCH_THR_IDX: state_next.fetch_thr = req.wdata[7:0];
                dbg_status_pkg::FETCH_REG_IDX: state_next.fetch_reg = req.wdata[4:0];
                dbg_status_pkg::CAUSE_IDX: begin
                    state_next.cause     = req.wdata[2:0];
                    state_next.cause_thr = req.wdata[15:8];
                    state_next.source    = req.wdata[17:16];
                end
                dbg_status_pkg::TRIG_DATA_IDX: state_next.data = req.wdata;
                dbg_status_pkg::STOP_MASK_IDX: state_next.stop_mask = req.wdata[7:0];
                default: ;
            endcase
        end
        // Hardware capture on debug entry wins over a software write
        if (entry.valid) begin
            state_next.status = entry.status & dbg_status_pkg::STATUS_CMASK;
            state_next.pc     = entry.pc;
            state_next.sp     = entry.sp;
            state_next.cause  = entry.cause;
            state_next.source = (entry.cause == dbg_status_pkg::CAUSE_IBRK ||
                                 entry.cause == dbg_status_pkg::CAUSE_DWATCH ||
                                 entry.cause == dbg_status_pkg::CAUSE_RWATCH)
                                ? lowest_hit : 2'h0;
            state_next.cause_thr = (entry.cause == dbg_status_pkg::CAUSE_HOST)
                                   ? 8'h00 : entry.thread;
            if (entry.cause == dbg_status_pkg::CAUSE_DWATCH ||
                entry.cause == dbg_status_pkg::CAUSE_RWATCH) begin
                state_next.data = entry.data;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign rdata          = state_reg.rdata;
    assign rvalid         = state_reg.rvalid;
    assign osc_enable     = state_reg.osc_en;
    assign thread_stop    = in_debug_mode ? 8'h00 : state_reg.stop_mask;
    assign fetch_thread   = state_reg.fetch_thr;
    assign fetch_register = state_reg.fetch_reg;

    a_count_upper: assert property (@(posedge core_clk) disable iff (!rst_n)
        $past(req.rd) && $past(req.idx) >= 8'h07 && $past(req.idx) <= 8'h0A
        |-> rdata[31:16] == 16'h0000) else $error("counter upper bits nonzero");
    a_ram_low: assert property (@(posedge core_clk) disable iff (!rst_n)
        $past(req.rd) && $past(req.idx) == 8'h0C |-> rdata[1:0] == 2'h0)
        else $error("ram size low bits nonzero");
    a_entry_pc: assert property (@(posedge core_clk) disable iff (!rst_n)
        entry.valid |=> state_reg.pc == $past(entry.pc) && state_reg.sp == $past(entry.sp))
        else $error("pc or sp not captured");
    a_status_ro: assert property (@(posedge core_clk) disable iff (!rst_n)
        !entry.valid |=> state_reg.status[8] == $past(state_reg.status[8]))
        else $error("status bit 8 written");
    a_host_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
        entry.valid && entry.cause == 3'h1 |=> state_reg.cause_thr == 8'h00
        && state_reg.source == 2'h0) else $error("host entry fields nonzero");
    a_lowest_src: assert property (@(posedge core_clk) disable iff (!rst_n)
        entry.valid && entry.cause >= 3'h3 && entry.cause <= 3'h5 && entry.hits != 4'h0
        |=> ((($past(entry.hits) >> state_reg.source) & 4'h1) == 4'h1)
        && (($past(entry.hits) & ((4'h1 << state_reg.source) - 4'h1)) == 4'h0))
        else $error("lowest source not chosen");
    a_drw_guard: assert property (@(posedge core_clk) disable iff (!rst_n)
        req.wr && !in_debug_mode && !entry.valid |=> $stable(state_reg.stop_mask)
        && $stable(state_reg.pc)) else $error("write outside debug accepted");
    a_stop_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
        in_debug_mode |-> thread_stop == 8'h00) else $error("threads stopped in debug");
    a_cause_rst: assert property (@(posedge core_clk)
        $rose(rst_n) |-> state_reg.cause == 3'h0) else $error("cause not reset");
    a_core_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        !$past(state_reg.osc_en[dbg_status_pkg::OSC_CORE_BIT])
        |-> $stable(osc_count_reg[0]) && $stable(osc_count_reg[1]))
        else $error("core counters moved while stopped");
    a_per_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        !$past(state_reg.osc_en[dbg_status_pkg::OSC_PER_BIT])
        |-> $stable(osc_count_reg[2]) && $stable(osc_count_reg[3]))
        else $error("peripheral counters moved while stopped");
    c_entry_dwatch: cover property (@(posedge core_clk) disable iff (!rst_n)
        entry.valid && entry.cause == 3'h4);
    c_stop_write: cover property (@(posedge core_clk) disable iff (!rst_n)
        req.wr && in_debug_mode && req.idx == 8'h18);
    c_scratch_read: cover property (@(posedge core_clk) disable iff (!rst_n)
        req.rd && req.idx == 8'h23);
endmodule // dbg_status_regs
`default_nettype wire

// *** pkg/dbg_status_pkg.sv ***
// Purpose: constants and carriers for the debug-state status register group
// Assumes: 8-bit register index, 32-bit data, one core clock at 100 MHz
// Notes: register indices are word numbers of the processor-status space
// Function
// - Counter value in low sixteen bits only
// - Counters at indices 0x07 to 0x0A
// - Counters survive system reset
// - RAM size in bits 31:2, read only
// - Debug entry captures saved status
// - Status copy flag layout, bit 8 read only
// - Debug entry captures saved program counter
// - Debug entry captures saved stack pointer
// - Fetch thread operand in bits 7:0
// - Fetch register operand in bits 4:0
// - Cause field resets zero, codes one to five
// - Source index recorded, zero for host/call
// - Lowest-numbered simultaneous trigger reported
// - Thread field recorded, zero for host
// - Trigger data takes address or resource id
// - Stop mask halts threads outside debug mode
// - Eight shared scratch words 0x20 to 0x27
// - Oscillator control: bit1 core, bit0 peripheral
`default_nettype none
package dbg_status_pkg;
    localparam logic [7:0] OSC_CTRL_IDX   = 8'h06;
    localparam logic [7:0] TILE_CELL_IDX  = 8'h07;
    localparam logic [7:0] TILE_WIRE_IDX  = 8'h08;
    localparam logic [7:0] PER_CELL_IDX   = 8'h09;
    localparam logic [7:0] PER_WIRE_IDX   = 8'h0A;
    localparam logic [7:0] RAM_SIZE_IDX   = 8'h0C;
    localparam logic [7:0] STATUS_IDX     = 8'h10;
    localparam logic [7:0] PC_IDX         = 8'h11;
    localparam logic [7:0] SP_IDX         = 8'h12;
    localparam logic [7:0] FETCH_THR_IDX  = 8'h13;
    localparam logic [7:0] FETCH_REG_IDX  = 8'h14;
    localparam logic [7:0] CAUSE_IDX      = 8'h15;
    localparam logic [7:0] TRIG_DATA_IDX  = 8'h16;
    localparam logic [7:0] STOP_MASK_IDX  = 8'h18;
    localparam logic [7:0] SCRATCH_IDX    = 8'h20;
    localparam logic [7:0] SCRATCH_MASK   = 8'hF8;
    localparam int         SCRATCH_WORDS  = 8;
    localparam int         OSC_COUNT      = 4;
    // Writable bits of the status copy; bit 8 and reserved bits excluded
    localparam logic [31:0] STATUS_WMASK  = 32'h0000_06DF;
    // Bits of the saved status kept on debug entry; bit 5 and bits above 10 reserved
    localparam logic [31:0] STATUS_CMASK  = 32'h0000_07DF;
    localparam logic [31:0] RAM_SIZE_BYTES = 32'h0004_0000;
    localparam logic [31:0] RAM_SIZE_MASK = 32'hFFFF_FFFC;
    localparam int          OSC_CORE_BIT  = 1;
    localparam int          OSC_PER_BIT   = 0;
    localparam int          OSC_STOP_NS   = 100;
    localparam int          CLK_PERIOD_NS = 10;
    localparam int          OSC_STOP_CYC  = (OSC_STOP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] CAUSE_NONE     = 3'h0;
    localparam logic [2:0] CAUSE_HOST     = 3'h1;
    localparam logic [2:0] CAUSE_CALL     = 3'h2;
    localparam logic [2:0] CAUSE_IBRK     = 3'h3;
    localparam logic [2:0] CAUSE_DWATCH   = 3'h4;
    localparam logic [2:0] CAUSE_RWATCH   = 3'h5;

    typedef struct packed {
        logic        valid;
        logic [2:0]  cause;
        logic [7:0]  thread;
        logic [3:0]  hits;
        logic [31:0] status;
        logic [31:0] pc;
        logic [31:0] sp;
        logic [31:0] data;
    } debug_entry_type;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [7:0]  idx;
        logic [31:0] wdata;
    } reg_req_type;

    typedef struct packed {
        logic [1:0]  osc_en;
        logic [31:0] status;
        logic [31:0] pc;
        logic [31:0] sp;
        logic [7:0]  fetch_thr;
        logic [4:0]  fetch_reg;
        logic [2:0]  cause;
        logic [1:0]  source;
        logic [7:0]  cause_thr;
        logic [31:0] data;
        logic [7:0]  stop_mask;
        logic [31:0] rdata;
        logic        rvalid;
    } ctrl_state_type;
endpackage
`default_nettype wire

// *** test/osc_source.sv ***
// Purpose: stand-in for the four free-running oscillators
// Assumes: each oscillator toggles only while its group is enabled
// Notes: half periods are unrelated to the core clock and to each other
`timescale 1ns/1ps
`default_nettype none
module osc_source (
    input  wire logic [1:0] osc_enable,
    output var  logic [3:0] osc_pulse
);
    initial osc_pulse = 4'h0;
    // Core group drives tile counters, peripheral group the others
    always #23 if (osc_enable[1]) osc_pulse[0] = ~osc_pulse[0];
    always #29 if (osc_enable[1]) osc_pulse[1] = ~osc_pulse[1];
    always #31 if (osc_enable[0]) osc_pulse[2] = ~osc_pulse[2];
    always #37 if (osc_enable[0]) osc_pulse[3] = ~osc_pulse[3];
endmodule // osc_source
`default_nettype wire

// *** test/debug_state_status_regs_tb.sv ***
// Purpose: self-checking bench for the debug-state register group
// Assumes: register model of words 0x00..0x3F kept beside the design
// Notes: oscillator counts are checked for layout, movement, hold while stopped and retention
`timescale 1ns/1ps
`default_nettype none
module debug_state_status_regs_tb;
    logic                            core_clk;
    logic                            rst_n;
    dbg_status_pkg::reg_req_type     req;
    logic                            in_debug_mode;
    dbg_status_pkg::debug_entry_type entry;
    logic [3:0]                      osc_pulse;
    logic [31:0]                     rdata;
    logic                            rvalid;
    logic [1:0]                      osc_enable;
    logic [7:0]                      thread_stop;
    logic [7:0]                      fetch_thread;
    logic [4:0]                      fetch_register;
    logic [31:0]                     mdl [0:63];
    logic [31:0]                     v;
    logic [31:0]                     cnt [0:3];
    integer                          fails, checked, seed, i, c, h, src;

    dbg_status_regs dut (.core_clk(core_clk), .rst_n(rst_n), .req(req),
        .in_debug_mode(in_debug_mode), .entry(entry), .osc_pulse(osc_pulse),
        .rdata(rdata), .rvalid(rvalid), .osc_enable(osc_enable),
        .thread_stop(thread_stop), .fetch_thread(fetch_thread),
        .fetch_register(fetch_register));
    osc_source osc (.osc_enable(osc_enable), .osc_pulse(osc_pulse));

    always #5 core_clk = ~core_clk;

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked = checked + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    function automatic logic [31:0] wmask(input logic [7:0] k);
        case (k)
            8'h06: wmask = 32'h0000_0003;
            8'h10: wmask = dbg_status_pkg::STATUS_WMASK;
            8'h11, 8'h12, 8'h16: wmask = 32'hFFFF_FFFF;
            8'h13, 8'h18: wmask = 32'h0000_00FF;
            8'h14: wmask = 32'h0000_001F;
            8'h15: wmask = 32'h0003_FF07;
            default: wmask = (k[7:3] == 5'h04) ? 32'hFFFF_FFFF : 32'h0000_0000;
        endcase
    endfunction

    task automatic wr(input logic [7:0] k, input logic [31:0] d);
        @(posedge core_clk);
        #1 req.wr = 1'b1;
        req.idx = k;
        req.wdata = d;
        @(posedge core_clk);
        #1 req.wr = 1'b0;
        if (k == 8'h06 || in_debug_mode)
            mdl[k[5:0]] = (mdl[k[5:0]] & ~wmask(k)) | (d & wmask(k));
    endtask

    task automatic rd(input logic [7:0] k, output logic [31:0] d);
        @(posedge core_clk);
        #1 req.rd = 1'b1;
        req.idx = k;
        @(posedge core_clk);
        #1 req.rd = 1'b0;
        check("rvalid", {31'h0, rvalid}, 32'h1);
        d = rdata;
    endtask

    task automatic rdc(input logic [7:0] k);
        rd(k, v);
        check($sformatf("reg %h", k), v, mdl[k[5:0]]);
    endtask

    task automatic enter(input logic [2:0] cs, input logic [3:0] hit);
        @(posedge core_clk);
        #1 entry.valid = 1'b1;
        entry.cause = cs;
        entry.hits = hit;
        entry.thread = 8'($random(seed));
        entry.status = $random(seed);
        entry.pc = $random(seed);
        entry.sp = $random(seed);
        entry.data = $random(seed);
        src = 0;
        if (cs >= 3'h3) for (h = 3; h >= 0; h--) if (hit[h]) src = h;
        mdl[6'h10] = entry.status & 32'h0000_07DF;
        mdl[6'h11] = entry.pc;
        mdl[6'h12] = entry.sp;
        mdl[6'h15] = {14'h0, 2'(src), (cs == 3'h1) ? 8'h00 : entry.thread, 5'h00, cs};
        if (cs == 3'h4 || cs == 3'h5) mdl[6'h16] = entry.data;
        @(posedge core_clk);
        #1 entry.valid = 1'b0;
    endtask

    task automatic give_verdict();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        #100000;
        fails = fails + 1;
        give_verdict();
    end

    initial begin
        core_clk = 1'b0;
        rst_n = 1'b0;
        req = '0;
        in_debug_mode = 1'b0;
        entry = '0;
        fails = 0;
        checked = 0;
        seed = 80368;
        for (i = 0; i < 64; i++) mdl[i] = 32'h0;
        mdl[6'h0C] = dbg_status_pkg::RAM_SIZE_BYTES & dbg_status_pkg::RAM_SIZE_MASK;
        repeat (10) @(posedge core_clk);
        #1 rst_n = 1'b1;
        for (i = 6; i < 16; i++) if (i < 7 || i > 10) rdc(8'(i));
        $display("test reset values done");
        for (c = 0; c < 2; c++) begin
            in_debug_mode = c[0];
            for (i = 16; i < 40; i++) begin
                wr(8'(i), $random(seed));
                rdc(8'(i));
            end
        end
        wr(8'h0C, $random(seed));
        rdc(8'h0C);
        check("stop in debug", 32'(thread_stop), 32'h0);
        check("fetch thread", 32'(fetch_thread), mdl[6'h13] & 32'hFF);
        check("fetch register", 32'(fetch_register), mdl[6'h14] & 32'h1F);
        in_debug_mode = 1'b0;
        @(posedge core_clk);
        #1 check("stop outside", 32'(thread_stop), mdl[6'h18] & 32'hFF);
        $display("test register access done");
        for (c = 1; c < 6; c++) begin
            h = $random(seed);
            enter(3'(c), 4'(h) | 4'h8);
            for (i = 16; i < 23; i++) rdc(8'(i));
        end
        $display("test debug entry done");
        wr(8'h06, 32'hFFFF_FFFF);
        rdc(8'h06);
        repeat (200) @(posedge core_clk);
        wr(8'h06, 32'h0);
        repeat (dbg_status_pkg::OSC_STOP_CYC) @(posedge core_clk);
        for (i = 0; i < 4; i++) begin
            rd(8'(i + 7), cnt[i]);
            check("count upper", cnt[i] & 32'hFFFF_0000, 32'h0);
            check("count moved", 32'(cnt[i] != 32'h0), 32'h1);
        end
        wr(8'h06, 32'h1);
        repeat (100) @(posedge core_clk);
        wr(8'h06, 32'h0);
        repeat (dbg_status_pkg::OSC_STOP_CYC) @(posedge core_clk);
        for (i = 0; i < 2; i++) begin
            rd(8'(i + 7), v);
            check("core count idle", v, cnt[i]);
        end
        for (i = 2; i < 4; i++) begin
            rd(8'(i + 7), v);
            check("periph count moved", 32'(v != cnt[i]), 32'h1);
            cnt[i] = v;
        end
        rst_n = 1'b0;
        repeat (3) @(posedge core_clk);
        #1 rst_n = 1'b1;
        for (i = 6; i < 64; i++) if (i != 12) mdl[i] = 32'h0;
        for (i = 0; i < 4; i++) begin
            rd(8'(i + 7), v);
            check("count kept", v, cnt[i]);
        end
        for (i = 16; i < 25; i++) rdc(8'(i));
        $display("test oscillators and reset done");
        give_verdict();
    end
endmodule // debug_state_status_regs_tb
`default_nettype wire
